// ===== design/lcs_regs.sv
// Per-channel change-status, cable-loss and pulse-segment register bank
`timescale 1ns/1ps
module lcs_regs
(
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    input  wire logic [13:0] EQ_FLAG,
    input  wire logic [13:0] DRV_MON,
    input  wire logic [13:0] RX_FIFO_LIMIT,
    input  wire logic [13:0] TX_FIFO_LIMIT,
    input  wire logic [13:0] CODE_VIOL,
    input  wire logic [13:0] VIOL_CNT_OVF,
    input  wire logic [13:0] LOOP_CODE,
    input  wire logic [13:0] ALL_ONES,
    input  wire logic [13:0] SIGNAL_LOSS,
    input  wire logic [13:0] PRBS_DETECT,
    input  wire logic [83:0] CABLE_LOSS,
    input  wire logic [111:0] CH_IRQ_ENABLE,
    input  wire logic        GLOBAL_IRQ_ENABLE,
    input  wire logic        OVF_SELECT,
    output logic      [13:0] SEG_SIGN,
    output logic      [83:0] SEG_MAG,
    output logic             IRQ
);
    // ------------------------------------------------------------
    // Input synchronisers for the analog-side alarms
    // ------------------------------------------------------------
    localparam int SYN_W = 10 * lcs_pkg::NUM_CH + lcs_pkg::NUM_CH * lcs_pkg::CLOSS_W;
    logic [SYN_W-1:0] syn1;
    logic [SYN_W-1:0] syn2;

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            syn1 <= '0;
            syn2 <= '0;
        end
        else
        begin
            syn1 <= {CABLE_LOSS, EQ_FLAG, DRV_MON, RX_FIFO_LIMIT, TX_FIFO_LIMIT, CODE_VIOL,
                     VIOL_CNT_OVF, LOOP_CODE, ALL_ONES, SIGNAL_LOSS, PRBS_DETECT};
            syn2 <= syn1;
        end
    end

    logic [13:0] s_eq;
    logic [13:0] s_drv;
    logic [13:0] s_rxf;
    logic [13:0] s_txf;
    logic [13:0] s_cv;
    logic [13:0] s_ovf;
    logic [13:0] s_loop;
    logic [13:0] s_ais;
    logic [13:0] s_los;
    logic [13:0] s_prbs;
    logic [83:0] s_closs;
    assign {s_closs, s_eq, s_drv, s_rxf, s_txf, s_cv, s_ovf, s_loop, s_ais, s_los,
            s_prbs} = syn2;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [3:0] ch_sel;
    logic [3:0] reg_sel;
    logic       ch_ok;
    assign ch_sel  = ADDR[7:4];
    assign reg_sel = ADDR[3:0];
    assign ch_ok   = (ch_sel < 4'(lcs_pkg::NUM_CH));

    // ------------------------------------------------------------
    // Per-channel logic
    // ------------------------------------------------------------
    logic [7:0]  change   [lcs_pkg::NUM_CH];
    logic [6:0]  seg      [lcs_pkg::NUM_CH][lcs_pkg::NUM_SEG_HERE];
    logic [13:0] fifo_src;
    logic [13:0] ch_pend;

    genvar g;
    generate
        for (g = 0; g < lcs_pkg::NUM_CH; g++)
        begin : gch
            lcs_chan_if cif ();
            logic cv_src;
            logic rd_hit;
            assign cv_src = OVF_SELECT ? s_ovf[g] : s_cv[g];
            assign cif.alarm = {s_eq[g], s_drv[g], s_rxf[g] | s_txf[g], cv_src,
                                s_loop[g], s_ais[g], s_los[g], s_prbs[g]};
            assign rd_hit = RD && ch_ok && ch_sel == 4'(g)
                            && reg_sel == lcs_pkg::OFF_CHANGE;
            assign cif.clr = rd_hit;
            assign change[g] = cif.change;
            // Transmit wins when both FIFOs reach their limit
            assign fifo_src[g] = s_txf[g];
            assign ch_pend[g] = |(cif.change & CH_IRQ_ENABLE[g*8 +: 8]);

            lcs_change_track u_trk
            (
                .clk   (MCLK),
                .rst_n (RST_N),
                .ch    (cif.tracker)
            );

            // Segment registers one to three; bit 7 is dropped
            for (genvar s = 0; s < lcs_pkg::NUM_SEG_HERE; s++)
            begin : gseg
                always_ff @(posedge MCLK or negedge RST_N)
                begin
                    if (!RST_N)
                        seg[g][s] <= lcs_pkg::SEG_RESET;
                    else if (WR && ch_ok && ch_sel == 4'(g)
                             && reg_sel == lcs_pkg::OFF_SEG1 + 4'(s))
                        seg[g][s] <= WDATA[6:0];
                end
            end

            // First segment drives the overshoot of the transmit pulse
            always_ff @(posedge MCLK or negedge RST_N)
            begin
                if (!RST_N)
                begin
                    SEG_SIGN[g]         <= 1'b0;
                    SEG_MAG[g*6 +: 6]   <= 6'h00;
                end
                else
                begin
                    SEG_SIGN[g]         <= seg[g][0][lcs_pkg::SEG_SIGN_BIT];
                    SEG_MAG[g*6 +: 6]   <= seg[g][0][5:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            IRQ <= 1'b0;
        else
            IRQ <= GLOBAL_IRQ_ENABLE && (|ch_pend);
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    logic [7:0] next_rdata;
    always_comb
    begin
        next_rdata = 8'h00;
        if (!ch_ok)
            next_rdata = 8'h00;
        else if (reg_sel == lcs_pkg::OFF_CHANGE)
            next_rdata = change[ch_sel];
        else if (reg_sel == lcs_pkg::OFF_FIFO_CL)
            next_rdata = {1'b0, fifo_src[ch_sel], s_closs[ch_sel*6 +: 6]};
        else if (reg_sel == lcs_pkg::OFF_SEG1)
            next_rdata = {1'b0, seg[ch_sel][0]};
        else if (reg_sel == lcs_pkg::OFF_SEG2)
            next_rdata = {1'b0, seg[ch_sel][1]};
        else if (reg_sel == lcs_pkg::OFF_SEG3)
            next_rdata = {1'b0, seg[ch_sel][2]};
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            RDATA <= 8'h00;
        else if (RD)
            RDATA <= next_rdata;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    irq_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        !GLOBAL_IRQ_ENABLE |=> !IRQ)
        else $error("interrupt without global enable");
    irq_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (GLOBAL_IRQ_ENABLE && ch_pend != 14'h0) |=> IRQ)
        else $error("interrupt not asserted for pending change");
    irq_cause_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        IRQ |-> $past(ch_pend) != 14'h0)
        else $error("interrupt without enabled change");
    seg_top_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (RD && ch_ok && reg_sel == lcs_pkg::OFF_SEG2) |=> !RDATA[7])
        else $error("segment bit 7 not zero");
    seg_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (WR && ch_sel == 4'h0 && reg_sel == lcs_pkg::OFF_SEG3)
        |=> seg[0][2] == $past(WDATA[6:0]))
        else $error("segment write lost");
    fifo_src_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (RD && ch_ok && reg_sel == lcs_pkg::OFF_FIFO_CL)
        |=> RDATA[lcs_pkg::FIFO_SRC_BIT] == $past(fifo_src[ch_sel]))
        else $error("fifo source bit wrong");
    closs_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (RD && ch_ok && reg_sel == lcs_pkg::OFF_FIFO_CL)
        |=> RDATA[5:0] == $past(s_closs[ch_sel*6 +: 6]))
        else $error("cable loss readout wrong");
    sign_out_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        ##1 SEG_SIGN[0] == $past(seg[0][0][6]))
        else $error("overshoot sign not driven");
    unmapped_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (RD && !ch_ok) |=> RDATA == 8'h00)
        else $error("unmapped channel read nonzero");

    irq_cov: cover property (@(posedge MCLK) disable iff (!RST_N) $rose(IRQ));
    clr_cov: cover property (@(posedge MCLK) disable iff (!RST_N)
        RD && reg_sel == lcs_pkg::OFF_CHANGE && change[ch_sel] != 8'h00);
    ovf_cov: cover property (@(posedge MCLK) disable iff (!RST_N) OVF_SELECT && s_ovf[0]);
endmodule : lcs_regs

// ===== include/lcs_pkg.sv
// Constants for the per-channel change-status and pulse-segment register group
package lcs_pkg;
    localparam int          NUM_CH        = 14;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;
    localparam int          SEG_W         = 7;
    localparam int          CLOSS_W       = 6;
    localparam int          NUM_SEG_HERE  = 3;
    localparam logic [3:0]  OFF_CHANGE    = 4'h6;
    localparam logic [3:0]  OFF_FIFO_CL   = 4'h7;
    localparam logic [3:0]  OFF_SEG1      = 4'h8;
    localparam logic [3:0]  OFF_SEG2      = 4'h9;
    localparam logic [3:0]  OFF_SEG3      = 4'ha;
    localparam logic [7:0]  CHANGE_RESET  = 8'h00;
    localparam logic [6:0]  SEG_RESET     = 7'h00;
    localparam int          FIFO_SRC_BIT  = 6;
    localparam int          SEG_SIGN_BIT  = 6;
    localparam int          LCV_BIT       = 4;
endpackage : lcs_pkg

// ===== include/lcs_chan_if.sv
// Interface between the register front end and one channel's change tracker
`timescale 1ns/1ps
interface lcs_chan_if;
    logic [7:0] alarm;
    logic       clr;
    logic [7:0] change;
    modport tracker (input alarm, input clr, output change);
    modport front   (output alarm, output clr, input change);
endinterface : lcs_chan_if

// ===== design/lcs_change_track.sv
// Change detector for one channel's eight real-time alarm bits
`timescale 1ns/1ps
module lcs_change_track
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    lcs_chan_if.tracker ch
);
    logic [7:0] prev;
    logic [7:0] toggled;

    assign toggled = ch.alarm ^ prev;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev <= 8'h00;
        else
            prev <= ch.alarm;
    end

    // Set wins over the read clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ch.change <= lcs_pkg::CHANGE_RESET;
        else if (ch.clr)
            ch.change <= toggled;
        else
            ch.change <= ch.change | toggled;
    end

    change_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (toggled != 8'h00) |=> ((ch.change & $past(toggled)) == $past(toggled)))
        else $error("change bit did not set");
    change_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ch.clr && toggled == 8'h00) |=> (ch.change == 8'h00))
        else $error("change bits not cleared by read");
endmodule : lcs_change_track

// ===== bench/lcs_regs_tb.sv
// Self-checking bench for the change-status and pulse-segment register bank
`timescale 1ns/1ps
module lcs_regs_tb;
    logic         mclk      = 1'b0;
    logic         rst_n     = 1'b0;
    logic [7:0]   addr      = 8'h00;
    logic [7:0]   wdata     = 8'h00;
    logic         wr        = 1'b0;
    logic         rd        = 1'b0;
    logic [13:0]  alm [10]  = '{default: '0};
    logic [83:0]  cable     = '0;
    logic [111:0] ch_en     = '0;
    logic         global_irq_enable       = 1'b0;
    logic         ovf_sel   = 1'b0;
    logic [7:0]   rdata;
    logic [13:0]  seg_sign;
    logic [83:0]  seg_mag;
    logic         irq;
    logic [7:0]   d;
    int           errors    = 0;
    int           checked   = 0;
    // Alarm array index feeding change bits 0..7
    int           src [8]   = '{9, 8, 7, 6, 4, 2, 1, 0};

    lcs_regs u_dut (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .EQ_FLAG(alm[0]), .DRV_MON(alm[1]), .RX_FIFO_LIMIT(alm[2]),
        .TX_FIFO_LIMIT(alm[3]), .CODE_VIOL(alm[4]), .VIOL_CNT_OVF(alm[5]),
        .LOOP_CODE(alm[6]), .ALL_ONES(alm[7]), .SIGNAL_LOSS(alm[8]), .PRBS_DETECT(alm[9]),
        .CABLE_LOSS(cable), .CH_IRQ_ENABLE(ch_en), .GLOBAL_IRQ_ENABLE(global_irq_enable),
        .OVF_SELECT(ovf_sel), .SEG_SIGN(seg_sign), .SEG_MAG(seg_mag), .IRQ(irq));

    always #5 mclk = ~mclk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk);
        addr = a; wdata = v; wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
    endtask : wreg

    task automatic rreg(input logic [7:0] a, output logic [7:0] v);
        @(negedge mclk);
        addr = a; rd = 1'b1;
        @(negedge mclk);
        rd = 1'b0;
        @(negedge mclk);
        v = rdata;
    endtask : rreg

    task automatic wait_irq(input logic exp);
        for (int i = 0; i < 20 && irq !== exp; i++) @(negedge mclk);
        if (irq !== exp)
        begin
            errors++;
            $display("interrupt wait ran out at %0t", $time);
        end
    endtask : wait_irq

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rreg(8'h06, d); chk(d, 8'h00);
        rreg(8'h08, d); chk(d, 8'h00);
        rreg(8'h0a, d); chk(d, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_change();
        alm[8][3] = 1'b1; cyc(5);
        rreg(8'h36, d); chk(d, 8'h02);
        rreg(8'h36, d); chk(d, 8'h00);
        rreg(8'h26, d); chk(d, 8'h00);
        for (int b = 0; b < 8; b++)
        begin
            alm[src[b]][0] = ~alm[src[b]][0]; cyc(5);
            rreg(8'h06, d); chk(d, 8'h01 << b);
        end
        $display("test change done");
    endtask : t_change

    task automatic t_irq();
        ch_en[25] = 1'b1; alm[8][3] = 1'b0; cyc(5);
        chk({7'h0, irq}, 8'h00);
        global_irq_enable = 1'b1; wait_irq(1'b1);
        chk({7'h0, irq}, 8'h01);
        rreg(8'h36, d); chk(d, 8'h02);
        wait_irq(1'b0); chk({7'h0, irq}, 8'h00);
        ch_en[25] = 1'b0; alm[8][3] = 1'b1; cyc(5);
        chk({7'h0, irq}, 8'h00);
        rreg(8'h36, d); chk(d, 8'h02);
        $display("test interrupt done");
    endtask : t_irq

    task automatic t_fifo();
        cable[35:30] = 6'h2b; alm[3][5] = 1'b1; cyc(5);
        rreg(8'h57, d); chk(d, 8'h6b);
        alm[2][5] = 1'b1; cyc(5);
        rreg(8'h57, d); chk(d, 8'h6b);
        alm[3][5] = 1'b0; cyc(5);
        wreg(8'h57, 8'hff);
        rreg(8'h57, d); chk(d, 8'h2b);
        $display("test fifo source done");
    endtask : t_fifo

    task automatic t_seg();
        wreg(8'hd8, 8'hff);
        rreg(8'hd8, d); chk(d, 8'h7f);
        chk({7'h0, seg_sign[13]}, 8'h01);
        chk({2'h0, seg_mag[83:78]}, 8'h3f);
        wreg(8'hd8, 8'h15); cyc(1);
        chk({7'h0, seg_sign[13]}, 8'h00);
        chk({2'h0, seg_mag[83:78]}, 8'h15);
        wreg(8'h19, 8'hc5);
        rreg(8'h19, d); chk(d, 8'h45);
        wreg(8'h1a, 8'h2a);
        rreg(8'h1a, d); chk(d, 8'h2a);
        rreg(8'h08, d); chk(d, 8'h00);
        wreg(8'he8, 8'h55);
        rreg(8'he8, d); chk(d, 8'h00);
        $display("test segments done");
    endtask : t_seg

    task automatic t_ovf();
        ovf_sel = 1'b1; cyc(5);
        rreg(8'h26, d);
        alm[4][2] = 1'b1; cyc(5);
        rreg(8'h26, d); chk(d, 8'h00);
        alm[5][2] = 1'b1; cyc(5);
        rreg(8'h26, d); chk(d, 8'h10);
        $display("test overflow select done");
    endtask : t_ovf

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_change();
        t_irq();
        t_fifo();
        t_seg();
        t_ovf();
        print_verdict();
    end
endmodule : lcs_regs_tb
